/* File: verilog/cbk_scheduler.sv */
// checkback scheduler: configuration, test scheduling, recovery, loopback and outputs
`timescale 1ns/1ns
// How it works
// - a new password is accepted whatever the selector position.
// - other settings change only with the selector at custom; else rejected.
// - major and minor relays each have a selectable contact polarity.
// - each of three user outputs has its own polarity, independent of function.
// - each user output monitors one of five functions.
// - delayed alarm sets when recovery window expires without recovery.
// - test in progress is active only on the initiator, whole test.
// - successful test sets after this module initiated and passed a test.
// - successful recovery pulses for one second on leaving recovery.
// - auto-disabled output is active while auto tests are off.
// - alarms are sealed, or momentary for five seconds.
// - a failed message retries up to the count, then logs a comms error.
// - retry count resets to 3, accepts 0 to 20, 0 means no retries.
// - with low power on, a reduced-power test precedes the full test.
// - four hour settings launch tests at hour start, deferred if busy.
// - duplicated hour settings give only one test for that hour.
// - periodic interval is whole hours; zero is rejected.
// - loopback keys carrier for 4 to 60 s, by command or switch.
// - after a failure, tests repeat at the recovery period in minutes.
// - three consecutive passes end recovery and resume normal scheduling.
// - window 1 to 24 hours; no recovery within it sets delayed alarm.
// - with sync enabled the master starts clock sync at 12:30 a.m.
// - with auto off, no scheduled tests (recovery retests still launch when not busy) and no nightly sync.
// - recovery only on master with recovery enabled; manual passes count.
// - a setting picks periodic or timed scheduling.
module cbk_scheduler
  import cbk_pkg::*;
#(
  parameter int unsigned SEC_TICKS = TICKS_PER_SEC
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CUSTOM_SEL,
  input wire logic IS_MASTER,
  input wire cbk_pkg::tod_t TOD,
  input wire logic SET_VALID,
  input wire cbk_pkg::set_cmd_t SET_CMD,
  input wire logic PWD_VALID,
  output logic SET_ACCEPT,
  output logic SET_REJECT,
  output logic PWD_ACCEPT,
  input wire logic MANUAL_TEST,
  input wire logic LOOP_CMD,
  input wire logic LOOP_SWITCH,
  input wire logic BUSY,
  input wire logic TEST_DONE,
  input wire logic TEST_PASS,
  input wire logic MSG_DONE,
  input wire logic MSG_OK,
  input wire logic MAJOR_EVENT,
  input wire logic MINOR_EVENT,
  input wire logic CLEAR_ALARMS,
  output logic TEST_START,
  output logic TEST_LOWPWR,
  output logic MSG_RETRY,
  output logic COMM_ERROR,
  output logic CARRIER_KEY,
  output logic SYNC_START,
  output logic MAJOR_RELAY,
  output logic MINOR_RELAY,
  output logic [NUM_USER-1:0] USER_OUT
);
  import cbk_pkg::*;

  // ==========================================================
  // one-second enable
  logic [$clog2(SEC_TICKS+1)-1:0] div_q;
  logic sec_en;
  always_ff @(posedge CLK) begin
    if (SRST || div_q == ($bits(div_q))'(SEC_TICKS - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign sec_en = (div_q == ($bits(div_q))'(SEC_TICKS - 1));

  // ==========================================================
  // configuration settings
  logic major_close_q, minor_close_q, sealed_q, lowpwr_q, sync_en_q, auto_en_q, rec_en_q, timed_q;
  logic [NUM_USER-1:0] ustate_q;
  user_fn_t udef_q [NUM_USER];
  logic [4:0] retry_q, period_q, window_q;
  logic [5:0] loop_q, recper_q;
  logic [4:0] time_q [NUM_TIMES];
  logic val_ok;

  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  always_comb begin
    case (SET_CMD.sel)
      SET_UDEF: val_ok = in_range(SET_CMD.value, 8'h00, 8'h04);
      SET_RETRY: val_ok = in_range(SET_CMD.value, 8'h00, {3'h0, RETRY_MAX});
      SET_TIME: val_ok = in_range(SET_CMD.value, 8'h00, 8'h17);
      SET_PERIOD: val_ok = in_range(SET_CMD.value, 8'h01, 8'h1F);
      SET_LOOP: val_ok = in_range(SET_CMD.value, {2'h0, LOOP_MIN}, {2'h0, LOOP_MAX});
      SET_RECPER: val_ok = in_range(SET_CMD.value, 8'h01, 8'h3F);
      SET_WINDOW: val_ok = in_range(SET_CMD.value, {3'h0, WIN_MIN}, {3'h0, WIN_MAX});
      SET_USTATE: val_ok = (SET_CMD.idx < 2'(NUM_USER));
      default: val_ok = 1'b1;
    endcase
    if (SET_CMD.sel == SET_UDEF && SET_CMD.idx >= 2'(NUM_USER)) begin
      val_ok = 1'b0;
    end
  end

  logic set_we;
  assign set_we = SET_VALID && CUSTOM_SEL && val_ok;
  assign SET_ACCEPT = set_we;
  assign SET_REJECT = SET_VALID && !set_we;
  assign PWD_ACCEPT = PWD_VALID;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      major_close_q <= 1'b1;
      minor_close_q <= 1'b1;
      sealed_q <= 1'b1;
      lowpwr_q <= 1'b0;
      sync_en_q <= 1'b0;
      auto_en_q <= 1'b1;
      rec_en_q <= 1'b0;
      timed_q <= 1'b0;
      ustate_q <= '1;
      retry_q <= RETRY_RESET;
      period_q <= PERIOD_RESET;
      window_q <= WIN_RESET;
      loop_q <= LOOP_RESET;
      recper_q <= RECPER_RESET;
      for (int i = 0; i < NUM_USER; i++) begin
        udef_q[i] <= FN_TESTING;
      end
      for (int i = 0; i < NUM_TIMES; i++) begin
        time_q[i] <= TIME_RESET;
      end
    end else if (set_we) begin
      case (SET_CMD.sel)
        SET_MAJOR: major_close_q <= SET_CMD.value[0];
        SET_MINOR: minor_close_q <= SET_CMD.value[0];
        SET_USTATE: ustate_q[SET_CMD.idx] <= SET_CMD.value[0];
        SET_UDEF: udef_q[SET_CMD.idx] <= user_fn_t'(SET_CMD.value[2:0]);
        SET_SEALED: sealed_q <= SET_CMD.value[0];
        SET_RETRY: retry_q <= SET_CMD.value[4:0];
        SET_LOWPWR: lowpwr_q <= SET_CMD.value[0];
        SET_TIME: time_q[SET_CMD.idx] <= SET_CMD.value[4:0];
        SET_PERIOD: period_q <= SET_CMD.value[4:0];
        SET_LOOP: loop_q <= SET_CMD.value[5:0];
        SET_RECPER: recper_q <= SET_CMD.value[5:0];
        SET_WINDOW: window_q <= SET_CMD.value[4:0];
        SET_SYNC: sync_en_q <= SET_CMD.value[0];
        SET_AUTO: auto_en_q <= SET_CMD.value[0];
        SET_RECEN: rec_en_q <= SET_CMD.value[0];
        SET_TIMED: timed_q <= SET_CMD.value[0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // test sequencing: optional low-power pass, then full power
  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_LOW = 3'b010,
    T_FULL = 3'b100
  } test_st_t;
  test_st_t tst_q;
  logic sched_req, launch, test_fin, test_ok;
  assign launch = (tst_q == T_IDLE) && !BUSY && (MANUAL_TEST || sched_req);
  assign TEST_START = launch || ((tst_q == T_LOW) && TEST_DONE);
  assign TEST_LOWPWR = launch && lowpwr_q;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tst_q <= T_IDLE;
    end else begin
      case (tst_q)
        T_IDLE: if (launch) tst_q <= lowpwr_q ? T_LOW : T_FULL;
        T_LOW: if (TEST_DONE) tst_q <= T_FULL;
        T_FULL: if (TEST_DONE) tst_q <= T_IDLE;
        default: tst_q <= T_IDLE;
      endcase
    end
  end
  assign test_fin = (tst_q == T_FULL) && TEST_DONE;
  assign test_ok = test_fin && TEST_PASS;

  // ==========================================================
  // automatic scheduling: timed hours or periodic hours
  logic hour_edge, hour_match, pend_q, deliver;
  logic [4:0] hours_q;
  assign hour_edge = sec_en && TOD.minute == 6'h00 && TOD.second == 6'h00;
  always_comb begin
    hour_match = 1'b0;
    // one flag per hour, so equal entries collapse into one test
    for (int i = 0; i < NUM_TIMES; i++) begin
      hour_match = hour_match | (time_q[i] == TOD.hour);
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      hours_q <= '0;
    end else if (hour_edge) begin
      hours_q <= (hours_q + 1'b1 >= period_q) ? 5'h00 : hours_q + 1'b1;
    end
  end
  logic rec_q, rec_due;
  logic sched_hit;
  assign sched_hit = hour_edge && auto_en_q && !rec_q &&
    (timed_q ? hour_match : (5'(hours_q + 1'b1) >= period_q));
  assign sched_req = pend_q;
  assign deliver = launch && !MANUAL_TEST;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pend_q <= 1'b0;
    end else if (sched_hit || rec_due) begin
      pend_q <= 1'b1; // busy carrier defers it; with auto off it is dropped
    end else if (deliver || !auto_en_q) begin
      pend_q <= 1'b0;
    end
  end

  // ==========================================================
  // carrier recovery
  logic [1:0] pass_cnt_q;
  logic [11:0] rec_min_q;
  logic [5:0] sec_cnt_q;
  logic win_expired, rec_ok_pulse, win_run;
  logic delayed_q;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sec_cnt_q <= '0;
    end else if (sec_en) begin
      sec_cnt_q <= (sec_cnt_q == 6'h3B) ? 6'h00 : sec_cnt_q + 1'b1;
    end
  end
  logic min_en;
  assign min_en = sec_en && sec_cnt_q == 6'h3B;
  always_ff @(posedge CLK) begin
    if (SRST || !rec_q || rec_due) begin
      rec_min_q <= '0;
    end else if (min_en) begin
      rec_min_q <= rec_min_q + 1'b1;
    end
  end
  assign rec_due = rec_q && min_en && (rec_min_q + 1'b1 >= 12'(recper_q));
  logic rec_enter;
  assign rec_enter = test_fin && !TEST_PASS && !rec_q && IS_MASTER && rec_en_q;
  assign rec_ok_pulse = rec_q && test_ok && pass_cnt_q == 2'(RECOVER_PASSES - 1);
  sec_timer #(.W(17)) u_window (
    .clk(CLK),
    .srst(SRST),
    .sec_en(sec_en),
    .load(rec_enter || rec_ok_pulse),
    .load_val(rec_enter ? 17'(window_q * 3600) : 17'h0_0000),
    .running(win_run),
    .expired(win_expired)
  );
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rec_q <= 1'b0;
    end else if (rec_enter) begin
      rec_q <= 1'b1;
    end else if (rec_ok_pulse || win_expired) begin
      rec_q <= 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST || rec_enter) begin
      pass_cnt_q <= '0;
    end else if (rec_q && test_fin) begin
      pass_cnt_q <= TEST_PASS ? pass_cnt_q + 1'b1 : 2'h0; // manual tests count too
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      delayed_q <= 1'b0;
    end else if (rec_q && win_expired) begin
      delayed_q <= 1'b1; // set wins over a clear in the same cycle
    end else if (rec_enter || CLEAR_ALARMS) begin
      delayed_q <= 1'b0;
    end
  end

  // ==========================================================
  // message retries
  logic [4:0] tries_q;
  always_ff @(posedge CLK) begin
    if (SRST || (MSG_DONE && (MSG_OK || tries_q >= retry_q))) begin
      tries_q <= '0;
    end else if (MSG_DONE) begin
      tries_q <= tries_q + 1'b1;
    end
  end
  assign MSG_RETRY = MSG_DONE && !MSG_OK && tries_q < retry_q;
  assign COMM_ERROR = MSG_DONE && !MSG_OK && tries_q >= retry_q;

  // ==========================================================
  // loopback keying and nightly sync
  logic loop_run, loop_start;
  assign loop_start = (LOOP_CMD || LOOP_SWITCH) && !loop_run;
  sec_timer #(.W(6)) u_loop (
    .clk(CLK),
    .srst(SRST),
    .sec_en(sec_en),
    .load(loop_start),
    .load_val(loop_q),
    .running(loop_run),
    .expired()
  );
  always_ff @(posedge CLK) begin
    if (SRST) begin
      CARRIER_KEY <= 1'b0;
    end else begin
      CARRIER_KEY <= loop_start || loop_run;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SYNC_START <= 1'b0;
    end else begin
      SYNC_START <= sec_en && IS_MASTER && sync_en_q && auto_en_q && TOD.hour == SYNC_HOUR &&
        TOD.minute == SYNC_MIN && TOD.second == 6'h00;
    end
  end

  // ==========================================================
  // status flags and contact outputs
  logic pass_q, recov_run, major_q, minor_q, mom_run_maj, mom_run_min;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pass_q <= 1'b0;
    end else if (test_ok) begin
      pass_q <= 1'b1;
    end else if (launch) begin
      pass_q <= 1'b0;
    end
  end
  sec_timer #(.W(3)) u_recov (
    .clk(CLK), .srst(SRST), .sec_en(sec_en), .load(rec_ok_pulse),
    .load_val(3'(RECOVER_PULSE_SEC + 1)), .running(recov_run), .expired()
  );
  // momentary timers are one second longer so the first partial second never shortens them
  sec_timer #(.W(3)) u_mom_maj (
    .clk(CLK), .srst(SRST), .sec_en(sec_en), .load(MAJOR_EVENT),
    .load_val(3'(MOMENTARY_SEC + 1)), .running(mom_run_maj), .expired()
  );
  sec_timer #(.W(3)) u_mom_min (
    .clk(CLK), .srst(SRST), .sec_en(sec_en), .load(MINOR_EVENT),
    .load_val(3'(MOMENTARY_SEC + 1)), .running(mom_run_min), .expired()
  );
  always_ff @(posedge CLK) begin
    if (SRST) begin
      major_q <= 1'b0;
      minor_q <= 1'b0;
    end else begin
      major_q <= MAJOR_EVENT || (major_q && !CLEAR_ALARMS && (sealed_q || mom_run_maj));
      minor_q <= MINOR_EVENT || (minor_q && !CLEAR_ALARMS && (sealed_q || mom_run_min));
    end
  end
  // a closing contact reads 1; polarity inverts when the setting asks to open
  always_ff @(posedge CLK) begin
    if (SRST) begin
      MAJOR_RELAY <= 1'b0;
      MINOR_RELAY <= 1'b0;
    end else begin
      MAJOR_RELAY <= major_close_q ? major_q : !major_q;
      MINOR_RELAY <= minor_close_q ? minor_q : !minor_q;
    end
  end
  logic [4:0] fn_vec;
  assign fn_vec = {!auto_en_q, recov_run, pass_q, tst_q != T_IDLE, delayed_q};
  for (genvar g = 0; g < NUM_USER; g++) begin : g_user
    always_ff @(posedge CLK) begin
      if (SRST) begin
        USER_OUT[g] <= 1'b0;
      end else begin
        USER_OUT[g] <= ustate_q[g] ? fn_vec[udef_q[g]] : !fn_vec[udef_q[g]];
      end
    end
  end

  // ==========================================================
  // checks
  property p_reject;
    @(posedge CLK) disable iff (SRST) (SET_VALID && !CUSTOM_SEL) |-> SET_REJECT && !SET_ACCEPT;
  endproperty
  a_reject: assert property (p_reject) else $error("setting taken outside custom");
  property p_pwd;
    @(posedge CLK) disable iff (SRST) PWD_VALID |-> PWD_ACCEPT;
  endproperty
  a_pwd: assert property (p_pwd) else $error("password refused");
  property p_comm;
    @(posedge CLK) disable iff (SRST) COMM_ERROR |-> MSG_DONE && !MSG_OK && !MSG_RETRY;
  endproperty
  a_comm: assert property (p_comm) else $error("comm error with retry pending");
  property p_loop;
    @(posedge CLK) disable iff (SRST) $rose(loop_run) |-> ##1 CARRIER_KEY;
  endproperty
  a_loop: assert property (p_loop) else $error("carrier not keyed in loopback");
  property p_low;
    @(posedge CLK) disable iff (SRST) (launch && lowpwr_q) |=> tst_q == T_LOW;
  endproperty
  a_low: assert property (p_low) else $error("low power test skipped");
  property p_rec_exit;
    @(posedge CLK) disable iff (SRST) rec_ok_pulse |=> !rec_q ##0 recov_run;
  endproperty
  a_rec_exit: assert property (p_rec_exit) else $error("recovery not ended on three passes");
  property p_fail_clr;
    @(posedge CLK) disable iff (SRST) (rec_q && test_fin && !TEST_PASS) |=> pass_cnt_q == 2'h0;
  endproperty
  a_fail_clr: assert property (p_fail_clr) else $error("pass count kept after fail");
  property p_delay;
    @(posedge CLK) disable iff (SRST) (rec_q && win_expired && !CLEAR_ALARMS) |=> delayed_q && !rec_q;
  endproperty
  a_delay: assert property (p_delay) else $error("delayed alarm missing");
  property p_sync_auto;
    @(posedge CLK) disable iff (SRST) SYNC_START |-> $past(auto_en_q) && $past(sync_en_q);
  endproperty
  a_sync_auto: assert property (p_sync_auto) else $error("sync sent with auto off");
  property p_retry_max;
    @(posedge CLK) disable iff (SRST) retry_q <= RETRY_MAX;
  endproperty
  a_retry_max: assert property (p_retry_max) else $error("retry count above limit");
  property p_win_run;
    @(posedge CLK) disable iff (SRST) rec_q |-> win_run;
  endproperty
  a_win_run: assert property (p_win_run) else $error("recovery without a running window");
endmodule // cbk_scheduler

/* File: verilog/cbk_pkg.sv */
// package: constants, settings layout and modes for the checkback scheduler
package cbk_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICKS_PER_SEC = CLK_HZ;
  localparam int unsigned MOMENTARY_SEC = 5;
  localparam int unsigned RECOVER_PULSE_SEC = 1;
  localparam int unsigned RECOVER_PASSES = 3;
  localparam logic [4:0] RETRY_RESET = 5'h03;
  localparam logic [4:0] RETRY_MAX = 5'h14;
  localparam logic [5:0] LOOP_MIN = 6'h04;
  localparam logic [5:0] LOOP_MAX = 6'h3C;
  localparam logic [5:0] LOOP_RESET = 6'h0A;
  localparam logic [4:0] WIN_MIN = 5'h01;
  localparam logic [4:0] WIN_MAX = 5'h18;
  localparam logic [4:0] WIN_RESET = 5'h03;
  localparam logic [4:0] PERIOD_RESET = 5'h04;
  localparam logic [5:0] RECPER_RESET = 6'h0F;
  localparam logic [4:0] SYNC_HOUR = 5'h00;
  localparam logic [5:0] SYNC_MIN = 6'h1E;
  localparam logic [4:0] TIME_RESET = 5'h01;
  localparam int unsigned NUM_USER = 3;
  localparam int unsigned NUM_TIMES = 4;

  typedef enum logic [2:0] {
    FN_DELAY = 3'h0,
    FN_TESTING = 3'h1,
    FN_PASS = 3'h2,
    FN_RECOVER = 3'h3,
    FN_DISABLE = 3'h4
  } user_fn_t;

  typedef enum logic [3:0] {
    SET_MAJOR = 4'h0,
    SET_MINOR = 4'h1,
    SET_USTATE = 4'h2,
    SET_UDEF = 4'h3,
    SET_SEALED = 4'h4,
    SET_RETRY = 4'h5,
    SET_LOWPWR = 4'h6,
    SET_TIME = 4'h7,
    SET_PERIOD = 4'h8,
    SET_LOOP = 4'h9,
    SET_RECPER = 4'hA,
    SET_WINDOW = 4'hB,
    SET_SYNC = 4'hC,
    SET_AUTO = 4'hD,
    SET_RECEN = 4'hE,
    SET_TIMED = 4'hF
  } set_sel_t;

  // one configuration write: selector, index for arrayed settings, value
  typedef struct packed {
    set_sel_t sel;
    logic [1:0] idx;
    logic [7:0] value;
  } set_cmd_t;

  // time of day from the clock outside
  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } tod_t;
endpackage

/* File: verilog/sec_timer.sv */
// down-counter in seconds, stepped by a one-second enable
`timescale 1ns/1ns
module sec_timer #(
  parameter int unsigned W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sec_en,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic running,
  output logic expired
);
  logic [W-1:0] cnt_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (sec_en && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  assign running = (cnt_q != '0);
  assign expired = sec_en && (cnt_q == {{(W-1){1'b0}}, 1'b1}) && !load;
endmodule // sec_timer

/* File: dv/remote_model.sv */
// far-end model: answers each test phase, alternately prompt and slow
`timescale 1ns/1ns
module remote_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic test_start,
  input wire logic signed [31:0] fail_upto,
  output logic test_done,
  output logic test_pass,
  output int n_start
);
  int cnt;
  // ==========
  // answer timing
  always @(posedge clk) begin
    test_done <= 1'b0;
    // qualifier toggles outside answers so a stale level is never trusted
    test_pass <= ~test_pass;
    if (srst) begin
      cnt <= 0;
      n_start <= 0;
      test_pass <= 1'b0;
    end else if (test_start) begin
      n_start <= n_start + 1;
      cnt <= (n_start % 2 == 1) ? 7 : 2;
    end else if (cnt == 1) begin
      cnt <= 0;
      test_done <= 1'b1;
      // phases numbered up to fail_upto fail, later ones pass
      test_pass <= (n_start > fail_upto);
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule // remote_model

/* File: dv/testbench.sv */
// self-checking bench for the checkback scheduler
`timescale 1ns/1ns
module testbench;
  import cbk_pkg::*;
  localparam int ST = 10;
  logic CLK, SRST, CUSTOM_SEL, IS_MASTER, SET_VALID, PWD_VALID, MANUAL_TEST, LOOP_CMD, LOOP_SWITCH, BUSY;
  logic MSG_DONE, MSG_OK, MAJOR_EVENT, MINOR_EVENT, CLEAR_ALARMS, TEST_DONE, TEST_PASS;
  logic SET_ACCEPT, SET_REJECT, PWD_ACCEPT, TEST_START, TEST_LOWPWR, MSG_RETRY, COMM_ERROR;
  logic CARRIER_KEY, SYNC_START, MAJOR_RELAY, MINOR_RELAY;
  logic [NUM_USER-1:0] USER_OUT;
  tod_t TOD;
  set_cmd_t SET_CMD;
  int error_cnt, n_compared, cyc, n_start, fail_upto, n, a, k, rt, n_low, n_sync, key_cyc;
  logic [31:0] rs = 32'h165b_81f8;
  logic [31:0] r;
  set_sel_t s;
  logic [7:0] v;
  set_cmd_t corner [16] = '{'{SET_RETRY, 2'h0, 8'h14}, '{SET_RETRY, 2'h0, 8'h15}, '{SET_RETRY, 2'h0, 8'h00},
    '{SET_PERIOD, 2'h0, 8'h00}, '{SET_PERIOD, 2'h0, 8'h01}, '{SET_LOOP, 2'h0, 8'h03}, '{SET_LOOP, 2'h0, 8'h04},
    '{SET_LOOP, 2'h0, 8'h3C}, '{SET_LOOP, 2'h0, 8'h3D}, '{SET_WINDOW, 2'h0, 8'h00}, '{SET_WINDOW, 2'h0, 8'h18},
    '{SET_WINDOW, 2'h0, 8'h19}, '{SET_TIME, 2'h3, 8'h17}, '{SET_TIME, 2'h3, 8'h18}, '{SET_RECPER, 2'h0, 8'h00},
    '{SET_UDEF, 2'h2, 8'h05}};

  cbk_scheduler #(.SEC_TICKS(ST)) cbk_scheduler_i (.CLK, .SRST, .CUSTOM_SEL, .IS_MASTER, .TOD, .SET_VALID,
    .SET_CMD, .PWD_VALID, .SET_ACCEPT, .SET_REJECT, .PWD_ACCEPT, .MANUAL_TEST, .LOOP_CMD, .LOOP_SWITCH, .BUSY,
    .TEST_DONE, .TEST_PASS, .MSG_DONE, .MSG_OK, .MAJOR_EVENT, .MINOR_EVENT, .CLEAR_ALARMS, .TEST_START,
    .TEST_LOWPWR, .MSG_RETRY, .COMM_ERROR, .CARRIER_KEY, .SYNC_START, .MAJOR_RELAY, .MINOR_RELAY, .USER_OUT);
  remote_model remote_model_i (.clk(CLK), .srst(SRST), .test_start(TEST_START), .fail_upto(fail_upto),
    .test_done(TEST_DONE), .test_pass(TEST_PASS), .n_start(n_start));

  // ==========
  // helpers
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic legal(set_cmd_t c);
    case (c.sel)
      SET_UDEF: return c.value <= 8'h04;
      SET_RETRY: return c.value <= 8'h14;
      SET_TIME: return c.value <= 8'h17;
      SET_PERIOD: return c.value inside {[8'h01:8'h1F]};
      SET_LOOP: return c.value inside {[8'h04:8'h3C]};
      SET_RECPER: return c.value inside {[8'h01:8'h3F]};
      SET_WINDOW: return c.value inside {[8'h01:8'h18]};
      default: return 1'b1;
    endcase
  endfunction
  task automatic check(logic [31:0] got, logic [31:0] exp, string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic ticks(int c);
    repeat (c) @(negedge CLK);
  endtask
  task automatic cfg(set_sel_t sl, logic [1:0] i, logic [7:0] val);
    logic ok;
    @(negedge CLK);
    SET_VALID = 1'b1;
    SET_CMD = '{sl, i, val};
    ok = CUSTOM_SEL & legal(SET_CMD);
    #1;
    check({SET_ACCEPT, SET_REJECT}, {ok, ~ok}, "set answer");
    check(PWD_ACCEPT, PWD_VALID, "password answer");
    @(negedge CLK);
    SET_VALID = 1'b0;
  endtask
  // one-cycle strobe on event inputs, bit order as in the concatenation
  task automatic hit(int b);
    @(negedge CLK);
    {LOOP_SWITCH, LOOP_CMD, MANUAL_TEST, CLEAR_ALARMS, MINOR_EVENT, MAJOR_EVENT} = 6'(1 << b);
    @(negedge CLK);
    {LOOP_SWITCH, LOOP_CMD, MANUAL_TEST, CLEAR_ALARMS, MINOR_EVENT, MAJOR_EVENT} = 6'h00;
  endtask
  task automatic do_reset();
    @(negedge CLK);
    SRST = 1'b1;
    repeat (10) @(negedge CLK);
    SRST = 1'b0;
    CUSTOM_SEL = 1'b1;
  endtask

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    n_low += TEST_LOWPWR;
    n_sync += SYNC_START;
    key_cyc += CARRIER_KEY;
    if (cyc == 90000) begin
      error_cnt++;
      test_done();
    end
  end

  // ==========
  // main sequence
  initial begin
    {SRST, CUSTOM_SEL, IS_MASTER, SET_VALID, PWD_VALID, BUSY, MSG_DONE, MSG_OK} = 8'h80;
    {LOOP_SWITCH, LOOP_CMD, MANUAL_TEST, CLEAR_ALARMS, MINOR_EVENT, MAJOR_EVENT} = 6'h00;
    {error_cnt, n_compared, cyc, fail_upto, n_low, n_sync, key_cyc} = '0;
    TOD = '{5'h0B, 6'h0B, 6'h0B};
    SET_CMD = '0;
    do_reset();
    repeat (60) begin
      r = rnd();
      CUSTOM_SEL = r[0] | r[1];
      PWD_VALID = r[2];
      s = set_sel_t'(r[7:4]);
      v = (s inside {SET_UDEF, SET_RETRY, SET_TIME, SET_PERIOD, SET_LOOP, SET_RECPER, SET_WINDOW}) ?
        {2'h0, r[21:16]} : {7'h00, r[8]};
      cfg(s, 2'(r[9:8] % 3), v);
    end
    PWD_VALID = 1'b0;
    CUSTOM_SEL = 1'b1;
    foreach (corner[j]) cfg(corner[j].sel, corner[j].idx, corner[j].value);
    $display("settings test ended");
    do_reset();
    check({MAJOR_RELAY, MINOR_RELAY}, 2'h0, "relays idle");
    hit(0);
    ticks(6 * ST);
    check(MAJOR_RELAY, 1'b1, "sealed major");
    hit(2);
    ticks(3);
    check(MAJOR_RELAY, 1'b0, "cleared major");
    cfg(SET_MAJOR, 2'h0, 8'h00);
    ticks(3);
    check(MAJOR_RELAY, 1'b1, "open polarity idle");
    cfg(SET_SEALED, 2'h0, 8'h00);
    hit(1);
    ticks(3 * ST);
    check(MINOR_RELAY, 1'b1, "momentary on");
    ticks(4 * ST);
    check(MINOR_RELAY, 1'b0, "momentary off");
    $display("relay test ended");
    do_reset();
    cfg(SET_UDEF, 2'h0, 8'(FN_PASS));
    cfg(SET_UDEF, 2'h1, 8'(FN_DISABLE));
    cfg(SET_USTATE, 2'h2, 8'h00);
    cfg(SET_LOWPWR, 2'h0, 8'h01);
    cfg(SET_AUTO, 2'h0, 8'h00);
    ticks(2);
    check(USER_OUT, 3'h6, "outputs idle, auto off");
    hit(3);
    ticks(1);
    check(USER_OUT, 3'h2, "test in progress");
    ticks(25);
    check(n_start, 2, "two test phases");
    check(n_low, 1, "low power phase first");
    check(USER_OUT, 3'h7, "passed test");
    @(negedge CLK);
    {MSG_DONE, MSG_OK} = 2'h3;
    #1;
    check({MSG_RETRY, COMM_ERROR}, 2'h0, "message success");
    @(negedge CLK);
    {MSG_DONE, MSG_OK} = 2'h0;
    for (a = 0; a < 2; a++) begin
      rt = (a == 0) ? 3 : 0;
      for (k = 0; k <= rt; k++) begin
        @(negedge CLK);
        MSG_DONE = 1'b1;
        #1;
        check({MSG_RETRY, COMM_ERROR}, (k == rt) ? 2'h1 : 2'h2, "message failure");
        @(negedge CLK);
        MSG_DONE = 1'b0;
      end
      cfg(SET_RETRY, 2'h0, 8'h00);
    end
    cfg(SET_LOOP, 2'h0, 8'h04);
    for (a = 4; a < 6; a++) begin
      key_cyc = 0;
      hit(a);
      ticks(6 * ST);
      check(key_cyc inside {[3 * ST + 1:4 * ST + 1]}, 1'b1, "loopback length");
    end
    $display("outputs, message and loopback test ended");
    do_reset();
    IS_MASTER = 1'b1;
    cfg(SET_TIMED, 2'h0, 8'h01);
    for (a = 0; a < 4; a++) cfg(SET_TIME, 2'(a), 8'h05);
    BUSY = 1'b1;
    TOD = '{5'h05, 6'h00, 6'h00};
    ticks(ST + 2);
    TOD = '{5'h05, 6'h00, 6'h01};
    ticks(2);
    check(n_start, 0, "deferred while busy");
    BUSY = 1'b0;
    ticks(30);
    check(n_start, 1, "one timed test");
    cfg(SET_TIMED, 2'h0, 8'h00);
    cfg(SET_PERIOD, 2'h0, 8'h02);
    for (a = 6; a < 8; a++) begin
      TOD = '{5'(a), 6'h00, 6'h00};
      ticks(ST);
      TOD = '{5'(a), 6'h00, 6'h01};
      ticks(20);
    end
    check(n_start, 2, "one periodic test in two hours");
    cfg(SET_SYNC, 2'h0, 8'h01);
    for (a = 1; a >= 0; a--) begin
      cfg(SET_AUTO, 2'h0, 8'(a));
      n_sync = 0;
      TOD = '{5'h00, 6'h1E, 6'h00};
      ticks(ST);
      TOD = '{5'h00, 6'h1F, 6'h00};
      ticks(3);
      check(n_sync, a, "nightly sync");
    end
    $display("schedule and sync test ended");
    do_reset();
    TOD = '{5'h0B, 6'h0B, 6'h0B};
    cfg(SET_RECEN, 2'h0, 8'h01);
    cfg(SET_RECPER, 2'h0, 8'h01);
    cfg(SET_WINDOW, 2'h0, 8'h01);
    cfg(SET_UDEF, 2'h0, 8'(FN_RECOVER));
    cfg(SET_UDEF, 2'h1, 8'(FN_DELAY));
    fail_upto = 2;
    hit(3);
    for (n = 0; USER_OUT[0] !== 1'b1 && n < 4000; n++) @(negedge CLK);
    check(n_start, 5, "tests until recovery");
    check(USER_OUT, 3'h1, "recovery pulse");
    ticks(3 * ST);
    check(USER_OUT[0], 1'b0, "recovery pulse ends");
    fail_upto = 100000;
    hit(3);
    for (n = 0; USER_OUT[1] !== 1'b1 && n < 40000; n++) @(negedge CLK);
    check(n inside {[34000:37500]}, 1'b1, "delayed alarm at window end");
    $display("recovery test ended");
    test_done();
  end
endmodule // testbench
